/* File: rtl/prot_chk.sv */
// Receive-side error checker and supervision timers of the protection entity.
// Assumes the parser presents one summarised message per msg_valid pulse and
// the protocol state machine gives start/stop pulses for each timer.
// Function
// - Missing mandatory element: indicate, discard, AN reports
// - Several missing: use the first one
// - Unrecognized elements: indicate, strip, continue processing
// - Several unrecognized: report the first one
// - Mandatory content error: indicate, discard, AN reports
// - Unexpected message: no state change, report, discard
// - Timer periods within ten percent
// - AN timer three, retransmit then error
// - LE timers one and two, retransmit then error
// - Timer four retries once; five never acts
// - Under four octets: indicate and discard
// - Fixed check precedence, no state change meanwhile
// - No PROTOCOL ERROR while timer four runs
`timescale 1ns/100ps
module prot_chk
    import prot_chk_pkg::*;
#(
    parameter int unsigned TICK_DIV   = TICK_CYCLES,
    parameter int unsigned SHORT_MS   = TSO_SHORT_MS,
    parameter int unsigned RESET_MS   = TSO4_MS,
    parameter int unsigned RESYNC_MS  = TSO5_MS
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                is_an,
    input  wire logic                msg_valid,
    input  wire msg_info_t           msg_info,
    output logic                     verdict_valid,
    output verdict_t                 verdict,
    output logic                     checking,
    input  wire logic [NUM_TMR-1:0]  tmr_start,
    input  wire logic [NUM_TMR-1:0]  tmr_stop,
    output logic [NUM_TMR-1:0]       tmr_running,
    output logic [NUM_TMR-1:0]       tmr_retx,
    output logic [NUM_TMR-1:0]       tmr_err_ind
);

    logic [21:0]            tick_cnt_q, tick_cnt_d;
    logic                   tick_q, tick_d;
    logic [TMR_W-1:0]       cnt_q [NUM_TMR];
    logic [TMR_W-1:0]       cnt_d [NUM_TMR];
    logic [NUM_TMR-1:0]     run_q, run_d;
    logic [NUM_TMR-1:0]     second_q, second_d;
    logic [NUM_TMR-1:0]     retx_q, retx_d;
    logic [NUM_TMR-1:0]     eind_q, eind_d;
    logic                   vv_q, vv_d;
    verdict_t               vd_q, vd_d;
    logic [TMR_W-1:0]       load_val [NUM_TMR];

    // Timer reload values, exact nominal so well inside tolerance
    assign load_val[T_SO1] = TMR_W'(SHORT_MS);
    assign load_val[T_SO2] = TMR_W'(SHORT_MS);
    assign load_val[T_SO3] = TMR_W'(SHORT_MS);
    assign load_val[T_SO4] = TMR_W'(RESET_MS);
    assign load_val[T_SO5] = TMR_W'(RESYNC_MS);

    // Millisecond tick generator
    always_comb begin
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q + 22'h1;
        if (tick_cnt_q == 22'(TICK_DIV - 1)) begin
            tick_cnt_d = 22'h0;
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 22'h0;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // Down-counters with first/second expiry tracking
    always_comb begin
        run_d    = run_q;
        second_d = second_q;
        retx_d   = '0;
        eind_d   = '0;
        for (int i = 0; i < NUM_TMR; i++) begin
            cnt_d[i] = cnt_q[i];
            if (tmr_stop[i]) begin
                // Normal stop on ACK or COM
                run_d[i]    = 1'b0;
                second_d[i] = 1'b0;
            end else if (tmr_start[i]) begin
                run_d[i]    = 1'b1;
                second_d[i] = 1'b0;
                cnt_d[i]    = load_val[i];
            end else if (run_q[i] && tick_q) begin
                if (cnt_q[i] <= TMR_W'(1)) begin
                    if (i == T_SO5) begin
                        // Always expires, no action
                        run_d[i] = 1'b0;
                    end else if (!second_q[i]) begin
                        // First expiry: retransmit and restart
                        retx_d[i]   = 1'b1;
                        second_d[i] = 1'b1;
                        cnt_d[i]    = load_val[i];
                    end else begin
                        // Second expiry: error to management
                        eind_d[i]   = 1'b1;
                        run_d[i]    = 1'b0;
                        second_d[i] = 1'b0;
                    end
                end else begin
                    cnt_d[i] = cnt_q[i] - TMR_W'(1);
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_q    <= '0;
            second_q <= '0;
            retx_q   <= '0;
            eind_q   <= '0;
            for (int i = 0; i < NUM_TMR; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            run_q    <= run_d;
            second_q <= second_d;
            retx_q   <= retx_d;
            eind_q   <= eind_d;
            for (int i = 0; i < NUM_TMR; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // Message checks in fixed precedence
    always_comb begin
        vv_d = msg_valid;
        vd_d = '0;
        if (msg_valid) begin
            vd_d.err_ind = 1'b1;
            vd_d.discard = 1'b1;
            if (msg_info.length < 8'(MIN_MSG_OCTETS)) begin
                vd_d.cause = CAUSE_SHORT;
            end else if (msg_info.mand_missing) begin
                vd_d.cause     = CAUSE_MAND_MISS;
                vd_d.diag      = msg_info.first_missing;
                vd_d.send_perr = is_an;
            end else if (msg_info.content_err) begin
                vd_d.cause     = CAUSE_CONTENT;
                vd_d.diag      = msg_info.content_ie;
                vd_d.send_perr = is_an;
            end else if (msg_info.unexpected) begin
                vd_d.cause     = CAUSE_UNEXPECTED;
                vd_d.diag      = msg_info.msg_type;
                vd_d.send_perr = is_an;
            end else if (msg_info.unrecog) begin
                vd_d.discard   = 1'b0;
                vd_d.strip     = 1'b1;
                vd_d.cause     = CAUSE_UNRECOG;
                vd_d.diag      = msg_info.first_unrecog;
                vd_d.send_perr = is_an;
            end else begin
                vd_d.err_ind = 1'b0;
                vd_d.discard = 1'b0;
            end
            // Suppress PROTOCOL ERROR while reset timer runs
            if (run_q[T_SO4]) begin
                vd_d.send_perr = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            vv_q <= 1'b0;
            vd_q <= '0;
        end else begin
            vv_q <= vv_d;
            vd_q <= vd_d;
        end
    end

    // Outputs; checking holds off state changes during the
    assign checking      = msg_valid;
    assign verdict_valid = vv_q;
    assign verdict       = vd_q;
    assign tmr_running   = run_q;
    assign tmr_retx      = retx_q;
    assign tmr_err_ind   = eind_q;

endmodule

/* File: rtl/prot_chk_pkg.sv */
// Constants and carriers for the protection message checker and timers.
// Assumes a single 40 MHz core clock.
package prot_chk_pkg;
    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned TICK_NS       = 1000000;                  // One millisecond
    localparam int unsigned TICK_CYCLES   = TICK_NS / 25;             // 25 ns period
    localparam int unsigned TSO_SHORT_MS  = 1500;
    localparam int unsigned TSO4_MS       = 20000;
    localparam int unsigned TSO5_MS       = 10000;
    localparam int unsigned MIN_MSG_OCTETS = 4;
    localparam int unsigned TMR_W         = 15;
    localparam int unsigned NUM_TMR       = 5;

    // Timer indices
    localparam int unsigned T_SO1 = 0;
    localparam int unsigned T_SO2 = 1;
    localparam int unsigned T_SO3 = 2;
    localparam int unsigned T_SO4 = 3;
    localparam int unsigned T_SO5 = 4;

    // Protocol error causes reported in the PROTOCOL ERROR message
    typedef enum logic [2:0] {
        CAUSE_NONE       = 3'h0,
        CAUSE_SHORT      = 3'h1,
        CAUSE_MAND_MISS  = 3'h2,
        CAUSE_UNRECOG    = 3'h3,
        CAUSE_CONTENT    = 3'h4,
        CAUSE_UNEXPECTED = 3'h5
    } cause_t;

    // Summary of one received message, produced by the parser
    typedef struct packed {
        logic [7:0] length;        // Octets received
        logic       mand_missing;  // Some mandatory element absent
        logic [7:0] first_missing; // Identifier of first absent element
        logic       unrecog;       // Some element not defined
        logic [7:0] first_unrecog; // Identifier of first undefined element
        logic       content_err;   // Bad length or codepoint
        logic [7:0] content_ie;    // Identifier of offending element
        logic       unexpected;    // Not allowed in current state
        logic [7:0] msg_type;      // Message type for the diagnostic
    } msg_info_t;

    // Verdict toward management and the transmitter
    typedef struct packed {
        logic       err_ind;   // Protocol error indication to management
        logic       discard;   // Message is ignored
        logic       strip;     // Unrecognized elements removed, go on
        logic       send_perr; // Send PROTOCOL ERROR
        cause_t     cause;
        logic [7:0] diag;
    } verdict_t;
endpackage

/* File: verif/prot_chk_monitor.sv */
// Checker for the protection message checker and its timers.
// Bound into every prot_chk instance; sees its ports only.
`timescale 1ns/100ps
module prot_chk_monitor
    import prot_chk_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               is_an,
    input wire logic               msg_valid,
    input wire msg_info_t          msg_info,
    input wire logic               verdict_valid,
    input wire verdict_t           verdict,
    input wire logic               checking,
    input wire logic [NUM_TMR-1:0] tmr_running,
    input wire logic [NUM_TMR-1:0] tmr_retx,
    input wire logic [NUM_TMR-1:0] tmr_err_ind
);
    // Long enough for the header checks
    wire len_ok = msg_info.length >= 8'(MIN_MSG_OCTETS);
    wire only_u = !(msg_info.mand_missing || msg_info.content_err || msg_info.unexpected);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Verdict timing, per-class reactions and timer behaviour
    a_verdict_next: assert property (msg_valid |=> verdict_valid)
        else $error("verdict missing");
    a_check_flag: assert property (checking == msg_valid)
        else $error("checking flag wrong");
    a_short_drop: assert property (msg_valid && !len_ok |=>
        verdict.discard && verdict.err_ind && !verdict.send_perr
        && verdict.cause == CAUSE_SHORT) else $error("short message kept");
    a_mand_first: assert property (msg_valid && len_ok
        && msg_info.mand_missing |=> verdict.discard
        && verdict.diag == $past(msg_info.first_missing)) else $error("bad mand");
    a_unrecog_strip: assert property (msg_valid && len_ok && only_u
        && msg_info.unrecog |=> verdict.strip && !verdict.discard
        && verdict.diag == $past(msg_info.first_unrecog)) else $error("bad strip");
    a_le_silent: assert property (verdict_valid && !$past(is_an) |-> !verdict.send_perr)
        else $error("LE sent error");
    a_tso4_quiet: assert property (verdict_valid && $past(tmr_running[T_SO4])
        && tmr_running[T_SO4] |-> !verdict.send_perr) else $error("error sent in reset");
    a_tso5_idle: assert property (!tmr_retx[T_SO5] && !tmr_err_ind[T_SO5])
        else $error("timer five acted");
    a_no_early: assert property ($rose(tmr_running[T_SO3]) |-> (!tmr_retx[T_SO3]) [*8])
        else $error("early expiry");
    a_err_stops: assert property (tmr_err_ind[T_SO3] |=> !tmr_running[T_SO3])
        else $error("timer runs on");
    // Main scenarios
    c_strip: cover property (verdict_valid && verdict.strip);
    c_retx: cover property (tmr_retx[T_SO3]);
    c_err: cover property (tmr_err_ind[T_SO4]);
endmodule
bind prot_chk prot_chk_monitor mon (.core_clk(core_clk), .rst(rst), .is_an(is_an),
    .msg_valid(msg_valid), .msg_info(msg_info), .verdict_valid(verdict_valid),
    .verdict(verdict), .checking(checking), .tmr_running(tmr_running),
    .tmr_retx(tmr_retx), .tmr_err_ind(tmr_err_ind));

/* File: verif/peer_model.sv */
// Peer entity model: delivers received message summaries.
// Drives on the falling edge; idle lines show the inverse of the last one.
`timescale 1ns/100ps
module peer_model
    import prot_chk_pkg::*;
(
    input  wire logic core_clk,
    output logic      msg_valid,
    output msg_info_t msg_info
);
    // Idle until the first message
    initial begin
        msg_valid = 1'b0;
        msg_info = '0;
    end
    // One message, held for one clock
    task automatic send(input msg_info_t m);
        @(negedge core_clk);
        msg_valid = 1'b1;
        msg_info = m;
        @(negedge core_clk);
        msg_valid = 1'b0;
        msg_info = ~m;
    endtask
endmodule

/* File: verif/tb_protection_msg_error_check_timers.sv */
// Bench for prot_chk with shortened tick and timer counts.
// Messages come from peer_model; timer commands from the bench.
`timescale 1ns/100ps
`define CHK(n, e, a) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        $display("mismatch %s exp %0h got %0h", n, e, a); \
        miscompares++; \
    end \
end
module tb_protection_msg_error_check_timers
    import prot_chk_pkg::*;
;
    localparam int SMS = 3;
    localparam int RMS = 5;
    localparam int YMS = 4;
    localparam int TDIV = 10;
    logic               core_clk;
    logic               rst;
    logic               is_an;
    logic               msg_valid;
    logic               verdict_valid;
    msg_info_t          msg_info;
    verdict_t           verdict;
    logic [NUM_TMR-1:0] tmr_start;
    logic [NUM_TMR-1:0] tmr_stop;
    logic [NUM_TMR-1:0] tmr_running;
    logic [NUM_TMR-1:0] tmr_retx;
    logic [NUM_TMR-1:0] tmr_err_ind;
    int                 miscompares = 0;
    int                 cmp_count = 0;
    peer_model peer (.core_clk(core_clk), .msg_valid(msg_valid), .msg_info(msg_info));
    prot_chk #(.TICK_DIV(TDIV), .SHORT_MS(SMS), .RESET_MS(RMS), .RESYNC_MS(YMS)) dut (
        .core_clk(core_clk), .rst(rst), .is_an(is_an), .msg_valid(msg_valid),
        .msg_info(msg_info), .verdict_valid(verdict_valid), .verdict(verdict),
        .checking(), .tmr_start(tmr_start), .tmr_stop(tmr_stop),
        .tmr_running(tmr_running), .tmr_retx(tmr_retx), .tmr_err_ind(tmr_err_ind));
    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic msg_info_t mk(input logic [7:0] len, input logic [3:0] f);
        mk = '{len, f[3], 8'h11, f[2], 8'h22, f[1], 8'h33, f[0], 8'h55};
    endfunction
    // Send one summary and judge its verdict
    task automatic chk(input msg_info_t m, input logic an, input cause_t c,
                       input logic [7:0] d, input logic disc, input logic p);
        is_an = an;
        peer.send(m);
        `CHK("valid", 1'b1, verdict_valid)
        `CHK("ind", c != CAUSE_NONE, verdict.err_ind)
        `CHK("cause", c, verdict.cause)
        `CHK("discard", disc, verdict.discard)
        `CHK("strip", c == CAUSE_UNRECOG, verdict.strip)
        `CHK("perr", p, verdict.send_perr)
        `CHK("diag", d, verdict.diag)
    endtask
    task automatic pulse(input int k, input logic stop);
        @(negedge core_clk);
        if (stop) tmr_stop[k] = 1'b1;
        else tmr_start[k] = 1'b1;
        @(negedge core_clk);
        tmr_start = '0;
        tmr_stop = '0;
    endtask
    // Cycles until timer k pulses or stops
    task automatic wait_evt(input int k, output int n);
        for (n = 1; n < 200; n++) begin
            @(negedge core_clk);
            if (tmr_retx[k] || tmr_err_ind[k] || !tmr_running[k]) return;
        end
        miscompares++;
        end_of_test();
    endtask
    task automatic t_timer(input int k, input int ms);
        int n;
        pulse(k, 1'b0);
        wait_evt(k, n);
        `CHK("first", k != T_SO5, tmr_retx[k])
        // First period depends on tick phase: between ms-1 and ms ticks
        `CHK("t1", 1'b1, n > (ms - 1) * TDIV && n <= ms * TDIV)
        if (k != T_SO5) begin
            wait_evt(k, n);
            `CHK("second", 1'b1, tmr_err_ind[k])
            `CHK("t2", ms * TDIV, n)
            @(negedge core_clk);
            `CHK("run", 1'b0, tmr_running[k])
        end
    endtask
    // Error classes in precedence order, then a clean message
    task automatic t_classes();
        chk(mk(8'h03, 4'hf), 1'b1, CAUSE_SHORT, 8'h00, 1'b1, 1'b0);
        chk(mk(8'h04, 4'hf), 1'b1, CAUSE_MAND_MISS, 8'h11, 1'b1, 1'b1);
        chk(mk(8'h04, 4'h7), 1'b0, CAUSE_CONTENT, 8'h33, 1'b1, 1'b0);
        chk(mk(8'h09, 4'h5), 1'b1, CAUSE_UNEXPECTED, 8'h55, 1'b1, 1'b1);
        chk(mk(8'hff, 4'h4), 1'b1, CAUSE_UNRECOG, 8'h22, 1'b0, 1'b1);
        chk(mk(8'h04, 4'h0), 1'b1, CAUSE_NONE, 8'h00, 1'b0, 1'b0);
    endtask
    // No PROTOCOL ERROR while the reset timer runs
    task automatic t_quiet();
        pulse(T_SO4, 1'b0);
        chk(mk(8'h06, 4'h8), 1'b1, CAUSE_MAND_MISS, 8'h11, 1'b1, 1'b0);
        pulse(T_SO4, 1'b1);
    endtask
    // A stopped timer stays idle
    task automatic t_stop();
        pulse(T_SO1, 1'b0);
        pulse(T_SO1, 1'b1);
        repeat (60) @(negedge core_clk);
        `CHK("stopped", 1'b0, tmr_running[T_SO1])
    endtask
    // Reset, then error classes, quiet reset window, stop, timers
    initial begin
        rst = 1'b1;
        is_an = 1'b0;
        tmr_start = '0;
        tmr_stop = '0;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        `CHK("idle", 5'h00, tmr_running)
        t_classes();
        t_quiet();
        t_stop();
        for (int k = 0; k < NUM_TMR; k++) t_timer(k, k == T_SO4 ? RMS : k == T_SO5 ? YMS : SMS);
        end_of_test();
    end
endmodule
